// ### pkg/ida_defines.vh
// constants for the indirect data addressing block
`ifndef IDA_DEFINES_VH
`define IDA_DEFINES_VH
`define IDA_AW 12
`define IDA_DW 8
`define IDA_PHI_MASK 8'h0f
// special register addresses of pointers and virtual operands
`define IDA_PTR0_LO 12'hfe9
`define IDA_PTR0_HI 12'hfea
`define IDA_PTR1_LO 12'hfe1
`define IDA_PTR1_HI 12'hfe2
`define IDA_PTR2_LO 12'hfd9
`define IDA_PTR2_HI 12'hfda
`define IDA_IND0_BASE 12'hfeb
`define IDA_IND1_BASE 12'hfe3
`define IDA_IND2_BASE 12'hfdb
// virtual operand kinds, offset from base
`define IDA_K_PLAIN 3'h4
`define IDA_K_POST_DECREMENT_OPERAND 3'h1
`define IDA_K_POST_INCREMENT_OPERAND 3'h2
`define IDA_K_PRE_INCREMENT_OPERAND 3'h3
`define IDA_K_WORKING_OFFSET_OPERAND 3'h0
`define IDA_ACC_SPLIT 8'h60
`define IDA_ACC_HI_PAGE 4'hf
`define IDA_ACC_LO_PAGE 4'h0
`define IDA_ONE 12'h001
`endif

// ### src/ida_pointer.v
// one pointer pair with auto-modify and direct byte access
`include "ida_defines.vh"
module ida_pointer #(
  parameter [11:0] LO_ADDR = 12'h000,
  parameter [11:0] HI_ADDR = 12'h001,
  parameter [11:0] IND_BASE = 12'h002
) (
  input wire mclk,
  input wire rst,
  input wire ce,
  input wire [11:0] addr,
  input wire acc_go,
  input wire wr_go,
  input wire [7:0] wdata,
  input wire [7:0] wreg,
  output wire hit_virt,
  output reg [11:0] eff_addr,
  output wire [11:0] ptr,
  output wire hit_reg,
  output wire [7:0] reg_rdata
);
  reg [11:0] ptr_r;
  reg [11:0] ptr_nxt;
  wire [11:0] diff;
  wire sel_lo;
  wire sel_hi;
  assign diff = addr - IND_BASE;
  assign hit_virt = (addr >= IND_BASE) && (diff <= {9'h000, `IDA_K_PLAIN});
  assign ptr = ptr_r;
  assign sel_lo = (addr == LO_ADDR);
  assign sel_hi = (addr == HI_ADDR);
  assign hit_reg = sel_lo | sel_hi;
  assign reg_rdata = sel_hi ? {4'h0, ptr_r[11:8]} : ptr_r[7:0];
  always @* begin
    eff_addr = ptr_r;
    ptr_nxt = ptr_r;
    if (hit_virt) begin
      case (diff[2:0])
        `IDA_K_PRE_INCREMENT_OPERAND: begin
          eff_addr = ptr_r + `IDA_ONE;
          ptr_nxt = ptr_r + `IDA_ONE;
        end
        `IDA_K_POST_INCREMENT_OPERAND: ptr_nxt = ptr_r + `IDA_ONE;
        `IDA_K_POST_DECREMENT_OPERAND: ptr_nxt = ptr_r - `IDA_ONE;
        `IDA_K_WORKING_OFFSET_OPERAND: eff_addr = ptr_r + {4'h0, wreg};
        default: ptr_nxt = ptr_r;
      endcase
    end
  end
  always @(posedge mclk) begin
    if (rst) begin
      ptr_r <= 12'h000;
    end else if (ce) begin
      if (wr_go && sel_lo) begin
        ptr_r <= {ptr_r[11:8], wdata};
      end else if (wr_go && sel_hi) begin
        ptr_r <= {wdata[3:0], ptr_r[7:0]};
      end else if (acc_go && hit_virt) begin
        ptr_r <= ptr_nxt;
      end
    end
  end
endmodule // ida_pointer

// ### src/ida_core.v
// data memory operand addressing with three pointer pairs
//
// Notes on behaviour
// - three 12-bit pointers, high nibble unused
// - indirect operand reads memory at its pointer
// - indirect access ignores bank select register
// - indirect operand reached with access bit zero, or with access bit one and bank select register 15
// - auto-modify operands: post_increment_operand, post_decrement_operand, pre_increment_operand; offset adds working register, pointer unchanged
// - pointers readable and writable as special registers
// - access bit zero selects access bank
// - full-address move ignores bank select register
// - destination bit picks source or working register
// - implicit destination fixed by the instruction
`include "ida_defines.vh"
module ida_core (
  input wire mclk,
  input wire rst,
  input wire ce,
  // -------------------------------------------------------------------------
  // instruction side
  // -------------------------------------------------------------------------
  input wire op_valid,
  input wire op_full,
  input wire [11:0] op_full_addr,
  input wire [7:0] op_file,
  input wire op_access,
  input wire op_has_dest,
  input wire op_dest,
  input wire op_impl_to_w,
  input wire op_rd,
  input wire op_wr,
  input wire [7:0] op_wdata,
  input wire [3:0] bank_select_register,
  input wire [7:0] wreg,
  // -------------------------------------------------------------------------
  // data memory side
  // -------------------------------------------------------------------------
  input wire [7:0] mem_rdata,
  output reg [11:0] mem_addr_r,
  output reg mem_rd_r,
  output reg mem_wr_r,
  output reg [7:0] mem_wdata_r,
  output reg [7:0] op_rdata_r,
  output reg op_rdata_valid_r,
  output reg res_to_w_r,
  output reg res_to_file_r,
  output reg [11:0] res_addr_r
);
  // -------------------------------------------------------------------------
  // address formation
  // -------------------------------------------------------------------------
  reg [11:0] raw_addr;
  wire go;
  wire wr_go;
  wire [2:0] hv;
  wire [2:0] hr;
  wire [11:0] ea0;
  wire [11:0] ea1;
  wire [11:0] ea2;
  wire [7:0] rr0;
  wire [7:0] rr1;
  wire [7:0] rr2;
  reg [11:0] fin_addr;
  reg ptr_reg_hit;
  reg [7:0] ptr_reg_data;
  reg to_w;
  reg to_file;
  assign go = op_valid & (op_rd | op_wr);
  always @* begin
    if (op_full) begin
      raw_addr = op_full_addr;
    end else if (!op_access) begin
      if (op_file >= `IDA_ACC_SPLIT) begin
        raw_addr = {`IDA_ACC_HI_PAGE, op_file};
      end else begin
        raw_addr = {`IDA_ACC_LO_PAGE, op_file};
      end
    end else begin
      raw_addr = {bank_select_register, op_file};
    end
  end
  assign wr_go = go & op_wr & ~(|hv);
  ida_pointer #(
    .LO_ADDR(`IDA_PTR0_LO),
    .HI_ADDR(`IDA_PTR0_HI),
    .IND_BASE(`IDA_IND0_BASE)
  ) u_ptr0 (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .addr(raw_addr),
    .acc_go(go),
    .wr_go(wr_go),
    .wdata(op_wdata),
    .wreg(wreg),
    .hit_virt(hv[0]),
    .eff_addr(ea0),
    .ptr(),
    .hit_reg(hr[0]),
    .reg_rdata(rr0)
  );
  ida_pointer #(
    .LO_ADDR(`IDA_PTR1_LO),
    .HI_ADDR(`IDA_PTR1_HI),
    .IND_BASE(`IDA_IND1_BASE)
  ) u_ptr1 (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .addr(raw_addr),
    .acc_go(go),
    .wr_go(wr_go),
    .wdata(op_wdata),
    .wreg(wreg),
    .hit_virt(hv[1]),
    .eff_addr(ea1),
    .ptr(),
    .hit_reg(hr[1]),
    .reg_rdata(rr1)
  );
  ida_pointer #(
    .LO_ADDR(`IDA_PTR2_LO),
    .HI_ADDR(`IDA_PTR2_HI),
    .IND_BASE(`IDA_IND2_BASE)
  ) u_ptr2 (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .addr(raw_addr),
    .acc_go(go),
    .wr_go(wr_go),
    .wdata(op_wdata),
    .wreg(wreg),
    .hit_virt(hv[2]),
    .eff_addr(ea2),
    .ptr(),
    .hit_reg(hr[2]),
    .reg_rdata(rr2)
  );
  // -------------------------------------------------------------------------
  // final address
  // -------------------------------------------------------------------------
  // a virtual operand replaces the decoded address by its pointer's target
  always @* begin
    fin_addr = raw_addr;
    if (hv[0]) begin
      fin_addr = ea0;
    end else if (hv[1]) begin
      fin_addr = ea1;
    end else if (hv[2]) begin
      fin_addr = ea2;
    end
  end
  // -------------------------------------------------------------------------
  // pointer register read data
  // -------------------------------------------------------------------------
  // high bytes read back with the unused nibble at zero
  always @* begin
    ptr_reg_hit = |hr;
    if (hr[0]) begin
      ptr_reg_data = rr0;
    end else if (hr[1]) begin
      ptr_reg_data = rr1;
    end else begin
      ptr_reg_data = rr2;
    end
  end
  // -------------------------------------------------------------------------
  // result destination
  // -------------------------------------------------------------------------
  // the destination bit, where present, wins over the implicit destination
  always @* begin
    if (op_has_dest) begin
      to_w = ~op_dest;
      to_file = op_dest;
    end else begin
      to_w = op_impl_to_w;
      to_file = ~op_impl_to_w;
    end
  end
  // -------------------------------------------------------------------------
  // request classification
  // -------------------------------------------------------------------------
  // a pointer register hit never reaches memory; virtual operands always do
  // a write to a virtual operand stores its data in memory, not in the pointer; auto-modify still steps the pointer
  wire virt_any;
  wire take_ptr;
  wire take_mem;
  assign virt_any = |hv;
  assign take_ptr = go & ptr_reg_hit & ~virt_any;
  assign take_mem = go & ~take_ptr;
  // -------------------------------------------------------------------------
  // next memory request
  // -------------------------------------------------------------------------
  reg [11:0] mem_addr_nxt;
  reg mem_rd_nxt;
  reg mem_wr_nxt;
  reg [7:0] mem_wdata_nxt;
  // address and data hold until the next request; strobes pulse once
  always @* begin
    mem_addr_nxt = mem_addr_r;
    mem_wdata_nxt = mem_wdata_r;
    mem_rd_nxt = 1'b0;
    mem_wr_nxt = 1'b0;
    if (go) begin
      mem_addr_nxt = fin_addr;
      mem_wdata_nxt = op_wdata;
    end
    if (take_mem) begin
      mem_rd_nxt = op_rd;
      mem_wr_nxt = op_wr;
    end
  end
  // -------------------------------------------------------------------------
  // next result destination
  // -------------------------------------------------------------------------
  reg res_to_w_nxt;
  reg res_to_file_nxt;
  reg [11:0] res_addr_nxt;
  // destination flags pulse in the cycle after each operand
  always @* begin
    res_to_w_nxt = 1'b0;
    res_to_file_nxt = 1'b0;
    res_addr_nxt = res_addr_r;
    if (op_valid) begin
      res_to_w_nxt = to_w;
      res_to_file_nxt = to_file;
      res_addr_nxt = fin_addr;
    end
  end
  // -------------------------------------------------------------------------
  // next read return
  // -------------------------------------------------------------------------
  // pointer register reads wait one extra cycle so that they land in the
  // same slot as memory reads; back to back requests then never collide
  reg ptr_rd_pend_r;
  reg ptr_rd_pend_nxt;
  reg [7:0] ptr_rd_data_r;
  reg [7:0] ptr_rd_data_nxt;
  reg [7:0] op_rdata_nxt;
  reg op_rdata_valid_nxt;
  always @* begin
    ptr_rd_pend_nxt = take_ptr & op_rd;
    ptr_rd_data_nxt = ptr_rd_data_r;
    if (take_ptr) begin
      ptr_rd_data_nxt = ptr_reg_data;
    end
    op_rdata_nxt = op_rdata_r;
    op_rdata_valid_nxt = 1'b0;
    // one request per cycle, so both sources never answer together
    if (mem_rd_r) begin
      op_rdata_nxt = mem_rdata;
      op_rdata_valid_nxt = 1'b1;
    end else if (ptr_rd_pend_r) begin
      op_rdata_nxt = ptr_rd_data_r;
      op_rdata_valid_nxt = 1'b1;
    end
  end
  // -------------------------------------------------------------------------
  // registered memory request
  // -------------------------------------------------------------------------
  // ce low freezes the request, strobes included
  always @(posedge mclk) begin
    if (rst) begin
      mem_addr_r <= 12'h000;
      mem_rd_r <= 1'b0;
      mem_wr_r <= 1'b0;
      mem_wdata_r <= 8'h00;
    end else if (ce) begin
      mem_addr_r <= mem_addr_nxt;
      mem_rd_r <= mem_rd_nxt;
      mem_wr_r <= mem_wr_nxt;
      mem_wdata_r <= mem_wdata_nxt;
    end
  end
  // -------------------------------------------------------------------------
  // registered result destination
  // -------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      res_to_w_r <= 1'b0;
      res_to_file_r <= 1'b0;
      res_addr_r <= 12'h000;
    end else if (ce) begin
      res_to_w_r <= res_to_w_nxt;
      res_to_file_r <= res_to_file_nxt;
      res_addr_r <= res_addr_nxt;
    end
  end
  // -------------------------------------------------------------------------
  // registered read return
  // -------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      ptr_rd_pend_r <= 1'b0;
      ptr_rd_data_r <= 8'h00;
      op_rdata_r <= 8'h00;
      op_rdata_valid_r <= 1'b0;
    end else if (ce) begin
      ptr_rd_pend_r <= ptr_rd_pend_nxt;
      ptr_rd_data_r <= ptr_rd_data_nxt;
      op_rdata_r <= op_rdata_nxt;
      op_rdata_valid_r <= op_rdata_valid_nxt;
    end
  end
endmodule // ida_core

// ### bench/ida_core_props.sv
// timing checker for the operand addressing block
module ida_core_props (
  input wire mclk, rst, ce, op_valid, op_full, op_access, op_has_dest, op_dest,
  input wire op_impl_to_w, op_rd, op_wr, mem_rd_r, mem_wr_r, op_rdata_valid_r,
  input wire res_to_w_r, res_to_file_r,
  input wire [11:0] op_full_addr, mem_addr_r, res_addr_r,
  input wire [7:0] op_file,
  input wire [3:0] bank_select_register
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire tk = ce && op_valid && (op_rd || op_wr);
  wire rdm = tk && op_rd && !op_full;
  a_full_move_addr: assert property (tk && op_rd && op_full && op_full_addr < 12'hf00
    |=> mem_rd_r && mem_addr_r == $past(op_full_addr)) else $error("full move address");
  a_banked_addr: assert property (rdm && op_access && bank_select_register != 4'hf
    |=> mem_addr_r == {$past(bank_select_register), $past(op_file)}) else $error("bank addr");
  a_access_low: assert property (rdm && !op_access && op_file < 8'h60
    |=> mem_rd_r && mem_addr_r == {4'h0, $past(op_file)}) else $error("access bank addr");
  a_dest_file: assert property (tk && op_has_dest && op_dest
    |=> res_to_file_r && !res_to_w_r) else $error("result not to file");
  a_dest_work: assert property (tk && op_has_dest && !op_dest
    |=> res_to_w_r && !res_to_file_r) else $error("result not to working reg");
  a_implicit_dest: assert property (tk && !op_has_dest
    |=> res_to_w_r == $past(op_impl_to_w)) else $error("implicit destination");
  a_read_answer: assert property (ce && mem_rd_r |=> op_rdata_valid_r)
    else $error("memory read not answered");
  a_ptr_no_mem: assert property (tk && op_wr && !op_full && !op_access
    && op_file inside {8'he9, 8'hea} |=> !mem_wr_r) else $error("pointer write hit memory");
  c_mem_read: cover property (mem_rd_r ##1 op_rdata_valid_r);
  c_mem_write: cover property (mem_wr_r);
  c_file_dest: cover property (res_to_file_r);
endmodule // ida_core_props
bind ida_core ida_core_props u_props (.*);

// ### bench/ida_mem_model.sv
// data memory array seen by the operand addressing block
module ida_mem_model (
  input wire mclk,
  input wire [11:0] mem_addr_r,
  input wire mem_rd_r,
  input wire mem_wr_r,
  input wire [7:0] mem_wdata_r,
  output wire [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:4095];
  logic [7:0] junk_r = 8'h5a;
  always @(posedge mclk) begin
    junk_r <= ~junk_r;
    if (mem_wr_r) mem[mem_addr_r] <= mem_wdata_r;
  end
  // noise when no read stands, so stale data never matches
  assign mem_rdata = mem_rd_r ? mem[mem_addr_r] : junk_r;
endmodule // ida_mem_model

// ### bench/indirect_data_addressing_tb_top.sv
// self-checking bench for the operand addressing block
module indirect_data_addressing_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst = 1, ce = 1, op_valid = 0, op_full = 0, op_access = 0, op_has_dest = 0;
  logic op_dest = 0, op_impl_to_w = 0, op_rd = 0, op_wr = 0;
  logic [11:0] op_full_addr = 12'h000, sa;
  logic [7:0] op_file = 8'h00, op_wdata = 8'h00, wreg = 8'h10, rv;
  logic [3:0] bank_select_register = 4'h5;
  wire [7:0] mem_rdata, op_rdata_r, mem_wdata_r;
  wire [11:0] mem_addr_r, res_addr_r;
  wire mem_rd_r, mem_wr_r, op_rdata_valid_r, res_to_w_r, res_to_file_r;
  logic sw, stw, stf, sr;
  int err_total = 0, n_tests = 0, i;
  ida_core u_dut (.*);
  ida_mem_model u_mem (.mclk, .mem_addr_r, .mem_rd_r, .mem_wr_r, .mem_wdata_r, .mem_rdata);
  initial forever #20 mclk = ~mclk;
  task chk(input string n, input logic [11:0] g, e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task go(input logic r, w, input logic [7:0] f, d);
    @(posedge mclk);
    op_valid <= 1; op_rd <= r; op_wr <= w; op_file <= f; op_wdata <= d;
    @(posedge mclk);
    op_valid <= 0; op_rd <= 0; op_wr <= 0;
    #1;
    sa = mem_addr_r;
    sw = mem_wr_r;
    sr = mem_rd_r;
    stw = res_to_w_r;
    stf = res_to_file_r;
    for (i = 0; r && i < 3 && op_rdata_valid_r !== 1'b1; i++) @(posedge mclk) #1;
    rv = op_rdata_r;
  endtask
  task t_pointers;
    go(0, 1, 8'he9, 8'h34);
    go(0, 1, 8'hea, 8'hf2);
    chk("ptr write", sw, 0);
    go(1, 0, 8'hea, 0);
    chk("ptr high", rv, 8'h02);
    go(0, 1, 8'hef, 8'ha5);
    chk("ind addr", sa, 12'h234);
    chk("ind wr", sw, 1);
    @(posedge mclk) #1;
    chk("ind data", u_mem.mem[12'h234], 8'ha5);
    go(1, 0, 8'hed, 0);
    chk("post_increment_operand", rv, 8'ha5);
    go(1, 0, 8'he9, 0);
    chk("ptr inc", rv, 8'h35);
    go(1, 0, 8'hec, 0);
    chk("post_decrement_operand", sa, 12'h235);
    go(1, 0, 8'hee, 0);
    chk("pre_increment_operand", sa, 12'h235);
    go(1, 0, 8'heb, 0);
    chk("working_offset_operand", sa, 12'h245);
    go(0, 1, 8'he9, 8'hff);
    go(0, 1, 8'hea, 8'h0f);
    go(1, 0, 8'hed, 0);
    go(1, 0, 8'hea, 0);
    chk("wrap", rv, 8'h00);
    go(1, 0, 8'he9, 0);
    chk("wrap lo", rv, 8'h00);
    go(0, 1, 8'hd9, 8'h77);
    go(0, 1, 8'hda, 8'h01);
    go(1, 0, 8'hdf, 0);
    chk("ptr2 ind", sa, 12'h177);
  endtask
  task t_hold;
    @(posedge mclk);
    ce <= 0;
    go(0, 1, 8'he1, 8'h55);
    @(posedge mclk);
    ce <= 1;
    go(1, 0, 8'he1, 0);
    chk("ce hold", rv, 8'h00);
    go(0, 1, 8'he1, 8'hc3);
    go(0, 1, 8'he2, 8'h07);
    go(1, 0, 8'he7, 0);
    chk("ptr1 ind", sa, 12'h7c3);
    chk("ind read", sr, 1);
  endtask
  task t_direct;
    op_access <= 1;
    go(1, 0, 8'h40, 0);
    chk("banked", sa, 12'h540);
    chk("banked rd", sr, 1);
    op_access <= 0;
    go(1, 0, 8'h40, 0);
    chk("acc low", sa, 12'h040);
    go(1, 0, 8'h80, 0);
    chk("acc high", sa, 12'hf80);
    op_full <= 1; op_full_addr <= 12'h3c1;
    go(1, 0, 8'h40, 0);
    chk("full move", sa, 12'h3c1);
    op_full <= 0; op_has_dest <= 1; op_dest <= 1;
    go(1, 0, 8'h10, 0);
    chk("to file", stf, 1);
    chk("res addr", res_addr_r, 12'h010);
    op_dest <= 0;
    go(1, 0, 8'h10, 0);
    chk("to w", stw, 1);
    op_has_dest <= 0; op_impl_to_w <= 1;
    go(1, 0, 8'h10, 0);
    chk("impl w", stw, 1);
    op_impl_to_w <= 0;
    go(1, 0, 8'h10, 0);
    chk("impl file", stf, 1);
  endtask
  task give_verdict;
    if (err_total == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 0;
    t_pointers;
    t_hold;
    t_direct;
    give_verdict;
  end
  initial begin
    #20000;
    err_total++;
    give_verdict;
  end
endmodule // indirect_data_addressing_tb_top
